// *** rtl/queue_cfg_pkg.sv ***
// package: command register layout, queue ids and carrier types for queue configuration
package queue_cfg_pkg;
  localparam int NUM_CHANNELS = 4;
  localparam int NUM_QUEUES = 9;
  localparam logic [7:0] OFFSET_GLOBAL_COMMAND = 8'h00;
  localparam int POS_RX_REQ_LO = 28;
  localparam int POS_TX_REQ_LO = 24;
  localparam int POS_CFG_REQ = 21;
  localparam int POS_ACTION_REQUEST = 0;
  localparam logic [31:0] RESET_GLOBAL_COMMAND = 32'h0000_0000;
  localparam logic [31:0] WRITABLE_MASK = 32'hFF20_0000;
  localparam logic [3:0] QUEUE_CFG = 4'h8;
  localparam logic [3:0] LAST_QUEUE = 4'h8;

  // one vector from a serial channel's receiver or transmitter
  typedef struct packed {
    logic valid;
    logic is_tx;
    logic [1:0] channel;
    logic [31:0] data;
  } vector_t;

  // one write toward an interrupt queue in memory
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } queue_write_t;
endpackage : queue_cfg_pkg

// *** rtl/interrupt_queue_config_command.sv ***
// global command register and interrupt vector queue configuration
`timescale 1ns/1ps
module interrupt_queue_config_command
  import queue_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [queue_cfg_pkg::NUM_QUEUES*32-1:0] queue_base_flat,
  input wire logic [queue_cfg_pkg::NUM_QUEUES*16-1:0] queue_length_flat,
  input wire queue_cfg_pkg::vector_t vector_in,
  output logic vector_ready,
  output queue_cfg_pkg::queue_write_t queue_write,
  output logic [queue_cfg_pkg::NUM_QUEUES-1:0] queue_configured,
  output logic config_done
);
  import queue_cfg_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_LOAD = 1'b1
  } cfg_state_t;

  logic [3:0] rx_req;
  logic [3:0] tx_req;
  logic cfg_req;
  logic action_request;
  cfg_state_t state;
  logic [NUM_QUEUES-1:0] pending;
  logic [3:0] load_idx;
  logic [31:0] base [NUM_QUEUES];
  logic [15:0] length [NUM_QUEUES];
  logic [15:0] wr_index [NUM_QUEUES];
  logic [3:0] target;
  logic cmd_hit;

  assign cmd_hit = reg_addr == OFFSET_GLOBAL_COMMAND;

  // selection bits only store; nothing happens until an action request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_req <= 4'h0;
      tx_req <= 4'h0;
      cfg_req <= 1'b0;
    end else if (reg_write && cmd_hit) begin
      rx_req <= reg_wdata[POS_RX_REQ_LO +: 4];
      tx_req <= reg_wdata[POS_TX_REQ_LO +: 4];
      cfg_req <= reg_wdata[POS_CFG_REQ];
    end
  end

  // action bit stays set while the queues load, then clears itself
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      action_request <= 1'b0;
    end else if (reg_write && cmd_hit && reg_wdata[POS_ACTION_REQUEST] && state == ST_IDLE) begin
      action_request <= 1'b1;
    end else if (state == ST_LOAD && pending == '0) begin
      action_request <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      if (cmd_hit) begin
        reg_rdata <= {rx_req, tx_req, 2'b00, cfg_req, 20'h0_0000, action_request} & (WRITABLE_MASK | 32'h1);
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // visits one queue index per cycle, selected or not, and loads it only if selected, so the base/length mux stays narrow
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      pending <= '0;
      load_idx <= 4'h0;
      config_done <= 1'b0;
    end else begin
      config_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (reg_write && cmd_hit && reg_wdata[POS_ACTION_REQUEST]) begin
            // selection written together with the action counts, so take it from the write data
            pending <= {reg_wdata[POS_CFG_REQ], reg_wdata[POS_TX_REQ_LO +: 4], reg_wdata[POS_RX_REQ_LO +: 4]};
            load_idx <= 4'h0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (pending == '0) begin
            state <= ST_IDLE;
            config_done <= 1'b1;
          end else begin
            pending[load_idx] <= 1'b0;
            load_idx <= (load_idx == LAST_QUEUE) ? 4'h0 : load_idx + 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // queue order: rx0..rx3, tx0..tx3, config
  generate
    for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          base[q] <= 32'h0000_0000;
          length[q] <= 16'h0000;
          wr_index[q] <= 16'h0000;
          queue_configured[q] <= 1'b0;
        end else if (state == ST_LOAD && pending[q] && load_idx == 4'(q)) begin
          base[q] <= queue_base_flat[q*32 +: 32];
          length[q] <= queue_length_flat[q*16 +: 16];
          wr_index[q] <= 16'h0000;
          queue_configured[q] <= 1'b1;
        end else if (queue_write.valid == 1'b0 && vector_in.valid && vector_ready && target == 4'(q)
                     && queue_configured[q]) begin
          // wraps at the programmed length; a zero length holds one entry
          wr_index[q] <= (wr_index[q] + 16'h1 >= length[q]) ? 16'h0000 : wr_index[q] + 16'h1;
        end
      end
    end
  endgenerate

  assign target = vector_in.is_tx ? {2'b01, vector_in.channel} : {2'b00, vector_in.channel};

  // vectors stall while a reconfiguration runs, so none land in a stale queue
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_ready <= 1'b0;
      queue_write <= '0;
    end else begin
      vector_ready <= state == ST_IDLE && !(reg_write && cmd_hit && reg_wdata[POS_ACTION_REQUEST]);
      queue_write.valid <= 1'b0;
      if (queue_write.valid == 1'b0 && vector_in.valid && vector_ready && queue_configured[target]) begin
        queue_write.valid <= 1'b1;
        queue_write.addr <= base[target] + {14'h0000, wr_index[target], 2'b00};
        queue_write.data <= vector_in.data;
      end
    end
  end

  // register image and selection storage
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rdata[23:22] == 2'b00) && (reg_rdata[20:14] == 7'h00))
    else $error("reserved bits not zero");
  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_read && !cmd_hit) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_sel_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && cmd_hit) |=> rx_req == $past(reg_wdata[31:28]) && cfg_req == $past(reg_wdata[21]))
    else $error("selection not stored");
  chk_tx_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && cmd_hit) |=> tx_req == $past(reg_wdata[27:24]))
    else $error("tx selection not stored");
  chk_sel_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_read && cmd_hit) |=> reg_rdata[31:21] == $past({rx_req, tx_req, 2'b00, cfg_req}))
    else $error("selection read back wrong");

  // action request and queue loading
  chk_no_action_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && !(reg_write && cmd_hit && reg_wdata[0])) |=> state == ST_IDLE)
    else $error("load without action request");
  chk_action_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && reg_write && cmd_hit && reg_wdata[0]) |=> action_request && state == ST_LOAD)
    else $error("action request not taken");
  chk_action_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(action_request) |-> ##[1:12] !action_request)
    else $error("action bit stuck");
  chk_done_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    config_done |-> state == ST_IDLE && !action_request)
    else $error("done while busy");
  chk_done_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    config_done |=> !config_done)
    else $error("done not a pulse");
  chk_load_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && reg_write && cmd_hit && reg_wdata[0])
      |=> pending == $past({reg_wdata[21], reg_wdata[27:24], reg_wdata[31:28]}))
    else $error("wrong queues selected");
  chk_unselected_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_LOAD && !pending[QUEUE_CFG]) |=> $stable(base[QUEUE_CFG]))
    else $error("unselected queue changed");
  chk_selected_loaded: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_LOAD && pending[load_idx]) |=> queue_configured[$past(load_idx)])
    else $error("selected queue not loaded");
  chk_cfg_base: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_LOAD && pending[QUEUE_CFG] && load_idx == QUEUE_CFG)
      |=> base[QUEUE_CFG] == $past(queue_base_flat[NUM_QUEUES*32-1 -: 32]))
    else $error("config queue base not taken");
  chk_index_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_idx <= LAST_QUEUE)
    else $error("load index past last queue");
  chk_configured_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (queue_configured & $past(queue_configured)) == $past(queue_configured))
    else $error("configured queue lost");

  // vector routing
  chk_busy_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_LOAD) |-> !queue_write.valid || $past(state) == ST_IDLE)
    else $error("write during load");
  chk_load_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_LOAD) |-> !vector_ready)
    else $error("vectors taken during load");
  chk_vector_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
    queue_write.valid |-> queue_write.data == $past(vector_in.data))
    else $error("queue write data wrong");
  chk_drop_unconfigured: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (vector_in.valid && !queue_configured[target]) |=> !queue_write.valid)
    else $error("vector written to unconfigured queue");
endmodule : interrupt_queue_config_command

// *** sim/host_queue_regs.sv ***
// host side model: queue base and length values
`timescale 1ns/1ps
module host_queue_regs
  import queue_cfg_pkg::*;
(
  output logic [NUM_QUEUES*32-1:0] queue_base_flat,
  output logic [NUM_QUEUES*16-1:0] queue_length_flat
);
  // held static: software programs them once, ahead of every action request
  always_comb begin
    for (int q = 0; q < NUM_QUEUES; q++) begin
      queue_base_flat[q*32 +: 32] = 32'h1000_0000 + 32'(q) * 32'h100;
      queue_length_flat[q*16 +: 16] = 16'h0010;
    end
  end
endmodule : host_queue_regs

// *** sim/testbench.sv ***
// self-checking bench for the global command register
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  import queue_cfg_pkg::*;
  logic sys_clk, reset_n, reg_write, reg_read, vector_ready, config_done;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [NUM_QUEUES*32-1:0] queue_base_flat;
  logic [NUM_QUEUES*16-1:0] queue_length_flat;
  logic [NUM_QUEUES-1:0] queue_configured;
  vector_t vector_in;
  queue_write_t queue_write;
  int err_count = 0;
  int comparisons = 0;
  host_queue_regs host (.queue_base_flat(queue_base_flat), .queue_length_flat(queue_length_flat));
  interrupt_queue_config_command uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .queue_base_flat(queue_base_flat), .queue_length_flat(queue_length_flat), .vector_in(vector_in),
    .vector_ready(vector_ready), .queue_write(queue_write), .queue_configured(queue_configured),
    .config_done(config_done));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    tick();
    reg_write = 0;
  endtask : reg_wr
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e, input string nm);
    reg_addr = a;
    reg_read = 1;
    tick();
    reg_read = 0;
    `CHECK(nm, e, reg_rdata)
  endtask : reg_check
  // selection only: nothing may be configured, reserved bits must read zero
  task automatic test_store;
    reg_wr(8'h00, 32'hFFFF_FFFE);
    repeat (12) tick();
    `CHECK("no setup", 9'h000, queue_configured)
    reg_check(8'h00, 32'hFF20_0000, "sel store");
    reg_check(8'h04, 32'h0, "unmapped");
    reg_wr(8'h00, 32'h0);
    reg_check(8'h00, 32'h0, "sel clear");
  endtask : test_store
  task automatic run_action(input logic [31:0] sel, input logic [8:0] e);
    int n;
    n = 0;
    reg_wr(8'h00, sel | 32'h1);
    reg_check(8'h00, sel | 32'h1, "busy");
    `CHECK("stall", 1'b0, vector_ready)
    while (config_done !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    `CHECK("done", 1'b1, config_done)
    `CHECK("configured", e, queue_configured)
    reg_check(8'h00, sel, "self clear");
  endtask : run_action
  task automatic send_vec(input logic tx, input logic [1:0] ch, input logic [31:0] ea);
    int n;
    n = 0;
    vector_in = '{1'b1, tx, ch, 32'h0000_00A5};
    // held until the queue write shows it was taken; a write in the cycle before refuses it
    tick();
    while (queue_write.valid !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    vector_in.valid = 1'b0;
    `CHECK("queue valid", 1'b1, queue_write.valid)
    `CHECK("queue addr", ea, queue_write.addr)
    `CHECK("queue data", 32'h0000_00A5, queue_write.data)
  endtask : send_vec
  // a vector for a queue never configured is dropped, not written
  task automatic test_drop;
    vector_in = '{1'b1, 1'b0, 2'd0, 32'h0000_005A};
    repeat (4) begin
      tick();
      `CHECK("drop", 1'b0, queue_write.valid)
    end
    vector_in.valid = 1'b0;
  endtask : test_drop
  task automatic close_out;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    #200000;
    err_count++;
    close_out();
  end
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    vector_in = '0;
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1;
    reg_check(8'h00, RESET_GLOBAL_COMMAND, "reset");
    test_store();
    run_action(32'h8000_0000, 9'h008);
    run_action(32'h0220_0000, 9'h128);
    run_action(32'h0, 9'h128);
    send_vec(1'b0, 2'd3, 32'h1000_0300);
    send_vec(1'b1, 2'd1, 32'h1000_0500);
    test_drop();
    close_out();
  end
endmodule : testbench
